// ### src/fla_pkg.sv
// package for flash lock and access decode: offsets, fields, codes, timing
package fla_pkg;
    localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hd1;
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 4;
    localparam int MAP_BIT = 3;
    localparam int SPACE_MSB = 2;
    localparam int SPACE_LSB = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
    localparam logic [3:0] KEY_FIRST = 4'h5;
    localparam logic [3:0] KEY_SECOND = 4'ha;
    localparam logic [1:0] SPACE_USER = 2'h0;
    localparam logic [1:0] SPACE_EXTRA_ROW = 2'h1;
    localparam logic [1:0] SPACE_SECURITY = 2'h2;
    localparam logic [1:0] SPACE_RESERVED = 2'h3;
    // lock bits are active low: 0 means programmed
    localparam logic [2:0] LOCK_DELIVERED = 3'h3;
    localparam logic [15:0] ROLL_LIMIT = 16'h7fff;
    // erase and program phase times
    localparam int ERASE_TIME_US = 5;
    localparam int PROGRAM_TIME_US = 5;
    localparam int CLK_MHZ = 10;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_ERASE = 2'b10,
        ST_PROGRAM = 2'b11
    } fla_state_type;
    typedef enum logic [1:0] {
        DST_XRAM = 2'b00,
        DST_EEPROM = 2'b01,
        DST_LATCH = 2'b10,
        DST_NONE = 2'b11
    } fla_dest_type;
endpackage

// ### src/fla_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module fla_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } fla_sync_state_type;
    fla_sync_state_type state;
    fla_sync_state_type next_state;

    initial begin
        if (WIDTH < 1) begin
            $error("fla_sync width must be at least one");
        end
    end

    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule

// ### src/fla_core.sv
// flash control register, lock levels and external-data access decode
// Contract
// - lock bits written only in parallel mode
// - delivered lock bits give level four
// - level one: no locks, table reads pass
// - level two: block reads, latch pin, refuse programming
// - level three adds verify refusal
// - level four adds roll-over execution block
// - key 5 then A launches chosen space
// - map bit maps column latch into data
// - busy set/cleared by hardware only
// - boot code reaches all nonvolatile spaces
// - external code reaches only eeprom data
// - flash written only through column latches
// - data read: eeprom only if enable and unmapped
// - data write: mapped goes latch if pin high
// - space codes user, extra row, security
// - any instruction between keys aborts launch; code re-arms instead when that instruction writes key 5 again
// - erase loaded locations then program them
`timescale 1ns/1ns
module fla_core #(
    parameter int ERASE_COUNT = fla_pkg::ERASE_CYCLES,
    parameter int PROGRAM_COUNT = fla_pkg::PROGRAM_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] flash_control,
    input wire logic instr_retire,
    input wire logic [15:0] program_counter,
    input wire logic exec_from_boot,
    input wire logic external_access_pin,
    input wire logic eeprom_window_enable,
    input wire logic xdata_read,
    input wire logic xdata_write,
    input wire logic table_read,
    input wire logic par_mode,
    input wire logic par_lock_write,
    input wire logic [2:0] par_lock_data,
    input wire logic par_program_req,
    input wire logic par_verify_req,
    output logic [2:0] lock_bits,
    output logic [1:0] xdata_dest,
    output logic table_read_blocked,
    output logic par_program_grant,
    output logic par_verify_grant,
    output logic external_exec_blocked,
    output logic external_access_latched,
    output logic nv_access_allowed,
    output logic erase_strobe,
    output logic program_strobe,
    output logic [1:0] program_space
);
    typedef struct packed {
        fla_pkg::fla_state_type fsm;
        logic [15:0] count;
        logic [3:0] key;
        logic map;
        logic [1:0] space;
        logic [2:0] locks;
        logic ea_latched;
        logic ea_taken;
        logic [1:0] ea_wait;
        logic busy;
        fla_pkg::fla_dest_type dest;
        logic tr_block;
        logic pp_grant;
        logic pv_grant;
        logic ext_block;
        logic nv_ok;
        logic erase_go;
        logic prog_go;
    } fla_state_type;
    fla_state_type state;
    fla_state_type next_state;

    logic ea_sync;
    logic lvl2;
    logic lvl3;
    logic lvl4;
    logic ctl_wr;
    logic ext_code;

    initial begin
        if (ERASE_COUNT < 1 || ERASE_COUNT > 65535 || PROGRAM_COUNT < 1
            || PROGRAM_COUNT > 65535) begin
            $error("fla_core phase counts out of range");
        end
    end

    fla_sync #(.WIDTH(1)) u_ea_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(external_access_pin),
        .sync_out(ea_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // lock levels; lower levels implied by higher ones
    always_comb begin
        lvl4 = !state.locks[2];
        lvl3 = lvl4 || !state.locks[1];
        lvl2 = lvl3 || !state.locks[0];
        ctl_wr = sfr_write && (sfr_addr == fla_pkg::FLASH_CONTROL_ADDR);
        // external code: pin low or fetch past the internal top
        ext_code = !state.ea_latched || (program_counter > fla_pkg::ROLL_LIMIT);
    end

    always_comb begin
        next_state = state;
        next_state.erase_go = 1'b0;
        next_state.prog_go = 1'b0;
        // pin caught once after reset release, then followed at level one and held from level two
        // wait out the synchroniser so its reset value is never taken
        if (!state.ea_taken) begin
            if (state.ea_wait == 2'h2) begin
                next_state.ea_latched = ea_sync;
                next_state.ea_taken = 1'b1;
            end else begin
                next_state.ea_wait = state.ea_wait + 2'h1;
            end
        end else if (!lvl2) begin
            next_state.ea_latched = ea_sync;
        end
        // only parallel mode touches the locks, never the cpu
        if (par_mode && par_lock_write) begin
            next_state.locks = par_lock_data;
        end
        next_state.pp_grant = par_mode && par_program_req && !lvl2;
        next_state.pv_grant = par_mode && par_verify_req && !lvl3;
        next_state.tr_block = table_read && ext_code && lvl2;
        next_state.ext_block = lvl4 && (program_counter > fla_pkg::ROLL_LIMIT);
        next_state.nv_ok = !ext_code || exec_from_boot;
        // external-data decode
        if (xdata_read) begin
            if (eeprom_window_enable && !state.map) begin
                next_state.dest = fla_pkg::DST_EEPROM;
            end else begin
                next_state.dest = fla_pkg::DST_XRAM;
            end
        end else if (xdata_write) begin
            if (state.map) begin
                next_state.dest = state.ea_latched ? fla_pkg::DST_LATCH
                                                   : fla_pkg::DST_XRAM;
            end else if (eeprom_window_enable) begin
                next_state.dest = fla_pkg::DST_EEPROM;
            end else begin
                next_state.dest = fla_pkg::DST_XRAM;
            end
        end else begin
            next_state.dest = fla_pkg::DST_NONE;
        end
        ////////////////////////////////////////////////////////////////////
        // control writes; busy bit never taken from software
        if (ctl_wr) begin
            next_state.key = sfr_wdata[fla_pkg::KEY_MSB:fla_pkg::KEY_LSB];
            next_state.map = sfr_wdata[fla_pkg::MAP_BIT];
            next_state.space = sfr_wdata[fla_pkg::SPACE_MSB:fla_pkg::SPACE_LSB];
        end
        case (state.fsm)
            fla_pkg::ST_IDLE: begin
                if (ctl_wr && sfr_wdata[7:4] == fla_pkg::KEY_FIRST) begin
                    next_state.fsm = fla_pkg::ST_ARMED;
                end
            end
            fla_pkg::ST_ARMED: begin
                if (ctl_wr && sfr_wdata[7:4] == fla_pkg::KEY_SECOND
                    && sfr_wdata[2:1] != fla_pkg::SPACE_RESERVED && !ext_code) begin
                    next_state.fsm = fla_pkg::ST_ERASE;
                    next_state.count = 16'(ERASE_COUNT - 1);
                    next_state.erase_go = 1'b1;
                end else if (ctl_wr && sfr_wdata[7:4] == fla_pkg::KEY_FIRST) begin
                    next_state.fsm = fla_pkg::ST_ARMED;
                end else if (ctl_wr || instr_retire) begin
                    next_state.fsm = fla_pkg::ST_IDLE;
                end
            end
            fla_pkg::ST_ERASE: begin
                if (state.count == 16'h0000) begin
                    next_state.fsm = fla_pkg::ST_PROGRAM;
                    next_state.count = 16'(PROGRAM_COUNT - 1);
                    next_state.prog_go = 1'b1;
                end else begin
                    next_state.count = state.count - 16'h0001;
                end
            end
            default: begin
                if (state.count == 16'h0000) begin
                    next_state.fsm = fla_pkg::ST_IDLE;
                end else begin
                    next_state.count = state.count - 16'h0001;
                end
            end
        endcase
        // busy kept in a flop so the register output is glitch free
        next_state.busy = (next_state.fsm == fla_pkg::ST_ERASE)
            || (next_state.fsm == fla_pkg::ST_PROGRAM);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
            state.locks <= fla_pkg::LOCK_DELIVERED;
            state.ea_latched <= 1'b1;
            state.dest <= fla_pkg::DST_NONE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy follows the phase machine only
    logic busy;
    assign busy = state.busy;
    assign flash_control = {state.key, state.map, state.space, busy};
    assign lock_bits = state.locks;
    assign xdata_dest = state.dest;
    assign table_read_blocked = state.tr_block;
    assign par_program_grant = state.pp_grant;
    assign par_verify_grant = state.pv_grant;
    assign external_exec_blocked = state.ext_block;
    assign external_access_latched = state.ea_latched;
    assign nv_access_allowed = state.nv_ok;
    assign erase_strobe = state.erase_go;
    assign program_strobe = state.prog_go;
    assign program_space = state.space;

    ////////////////////////////////////////////////////////////////////////
    sequence s_first_key;
        ctl_wr && sfr_wdata[7:4] == fla_pkg::KEY_FIRST && state.fsm == fla_pkg::ST_IDLE;
    endsequence
    sequence s_second_key;
        state.fsm == fla_pkg::ST_ARMED && ctl_wr && sfr_wdata[7:4] == fla_pkg::KEY_SECOND
            && sfr_wdata[2:1] != 2'h3 && !ext_code;
    endsequence
    a_first_arm: assert property (@(posedge core_clk) disable iff (!rstn)
        s_first_key |=> state.fsm == fla_pkg::ST_ARMED)
        else $error("first key did not arm");
    a_key_launch: assert property (@(posedge core_clk) disable iff (!rstn)
        s_second_key |=> busy && erase_strobe)
        else $error("key pair did not launch");
    a_lone_second: assert property (@(posedge core_clk) disable iff (!rstn)
        (state.fsm == fla_pkg::ST_IDLE && ctl_wr) |=> !busy)
        else $error("lone key started programming");
    a_abort_gap: assert property (@(posedge core_clk) disable iff (!rstn)
        (state.fsm == fla_pkg::ST_ARMED && instr_retire && !ctl_wr) |=> !busy)
        else $error("launch not aborted");
    a_busy_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (busy && ctl_wr && !sfr_wdata[0] && state.count != 16'h0000) |=> busy)
        else $error("software changed busy");
    a_erase_then_prog: assert property (@(posedge core_clk) disable iff (!rstn)
        program_strobe |-> $past(state.fsm) == fla_pkg::ST_ERASE)
        else $error("program without erase");
    a_read_decode: assert property (@(posedge core_clk) disable iff (!rstn)
        xdata_read |=> xdata_dest == (($past(eeprom_window_enable) && !$past(state.map))
            ? fla_pkg::DST_EEPROM : fla_pkg::DST_XRAM))
        else $error("read decode wrong");
    a_write_map: assert property (@(posedge core_clk) disable iff (!rstn)
        (xdata_write && state.map) |=> xdata_dest ==
            ($past(state.ea_latched) ? fla_pkg::DST_LATCH : fla_pkg::DST_XRAM))
        else $error("mapped write decode wrong");
    a_lock_cpu: assert property (@(posedge core_clk) disable iff (!rstn)
        !par_mode |=> $stable(lock_bits))
        else $error("locks changed outside parallel mode");
    a_verify_lock: assert property (@(posedge core_clk) disable iff (!rstn)
        lvl3 |=> !par_verify_grant)
        else $error("verify granted while locked");
    a_roll_block: assert property (@(posedge core_clk) disable iff (!rstn)
        (lvl4 && program_counter > 16'h7fff) |=> external_exec_blocked)
        else $error("roll-over not blocked");
endmodule

// ### sim/fla_cpu_model.sv
// behavioural cpu core model: special register writes, data moves, table reads
`timescale 1ns/1ns
module fla_cpu_model (
    input wire logic core_clk,
    output logic sfr_write,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic instr_retire,
    output logic xdata_read,
    output logic xdata_write,
    output logic table_read
);
    initial begin
        {sfr_write, instr_retire, xdata_read, xdata_write, table_read} = 5'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
    end
    // released bus lines are inverted so no stale value looks valid
    task automatic wr(input logic [7:0] data);
        @(negedge core_clk);
        sfr_write = 1'b1;
        sfr_addr = fla_pkg::FLASH_CONTROL_ADDR;
        sfr_wdata = data;
        @(negedge core_clk);
        sfr_write = 1'b0;
        sfr_addr = ~sfr_addr;
        sfr_wdata = ~data;
    endtask
    // key pair on consecutive instructions, nothing retired between
    task automatic launch(input logic [1:0] space);
        wr({fla_pkg::KEY_FIRST, 1'b0, space, 1'b0});
        wr({fla_pkg::KEY_SECOND, 1'b0, space, 1'b0});
    endtask
    // 0 retire, 1 data read, 2 data write, 3 table read
    task automatic pulse(input int kind);
        @(negedge core_clk);
        {table_read, xdata_write, xdata_read, instr_retire} = 4'h1 << kind;
        @(negedge core_clk);
        {table_read, xdata_write, xdata_read, instr_retire} = 4'h0;
    endtask
endmodule

// ### sim/flash_lock_and_access_decode_test.sv
// self-checking bench for flash lock and access decode
`timescale 1ns/1ns
module flash_lock_and_access_decode_test;
    logic core_clk = 1'b0, rstn = 1'b0, exec_from_boot = 1'b1, pin = 1'b1, eee = 1'b0;
    logic par_mode = 1'b0, par_lock_write = 1'b0, par_prog = 1'b0, par_ver = 1'b0;
    logic [2:0] par_lock_data = 3'h7;
    logic [15:0] pc = 16'h0000;
    logic sfr_write, instr_retire, xdata_read, xdata_write, table_read;
    logic [7:0] sfr_addr, sfr_wdata, fc;
    logic [2:0] lock_bits;
    logic [1:0] dest, space;
    logic tblk, pgr, vgr, xblk, erase_strobe, program_strobe, ea_lat, nv_ok;
    int mismatches = 0, samples_checked = 0, n_erase = 0, n_prog = 0;
    always #50 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        n_erase += erase_strobe;
        n_prog += program_strobe;
    end
    fla_cpu_model i_cpu (.core_clk(core_clk), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .instr_retire(instr_retire), .xdata_read(xdata_read),
        .xdata_write(xdata_write), .table_read(table_read));
    fla_core #(.ERASE_COUNT(3), .PROGRAM_COUNT(3)) i_dut (.core_clk(core_clk), .rstn(rstn),
        .sfr_write(sfr_write), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .flash_control(fc),
        .instr_retire(instr_retire), .program_counter(pc), .exec_from_boot(exec_from_boot),
        .external_access_pin(pin), .eeprom_window_enable(eee), .xdata_read(xdata_read),
        .xdata_write(xdata_write), .table_read(table_read), .par_mode(par_mode),
        .par_lock_write(par_lock_write), .par_lock_data(par_lock_data),
        .par_program_req(par_prog), .par_verify_req(par_ver), .lock_bits(lock_bits),
        .xdata_dest(dest), .table_read_blocked(tblk), .par_program_grant(pgr),
        .par_verify_grant(vgr), .external_exec_blocked(xblk), .external_access_latched(ea_lat),
        .nv_access_allowed(nv_ok), .erase_strobe(erase_strobe), .program_strobe(program_strobe),
        .program_space(space));
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic set_lock(input logic [2:0] v, input logic mode);
        @(negedge core_clk);
        {par_mode, par_lock_write, par_lock_data} = {mode, 1'b1, v};
        @(negedge core_clk);
        par_lock_write = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    // runs a launch and expects busy for the full erase and program time, or never
    task automatic try_launch(input logic [1:0] sp, input logic retire, input int exp_busy);
        int busy_n;
        int e0;
        busy_n = 0;
        e0 = n_erase;
        i_cpu.wr({fla_pkg::KEY_FIRST, 1'b0, sp, 1'b0});
        if (retire) i_cpu.pulse(0);
        i_cpu.wr({fla_pkg::KEY_SECOND, 1'b0, sp, 1'b0});
        // busy rises before the second write returns, so sample first
        for (int i = 0; i < 40; i++) begin
            busy_n += (fc[fla_pkg::BUSY_BIT] === 1'b1);
            @(negedge core_clk);
        end
        chk("busy cycles", busy_n[7:0], exp_busy[7:0]);
        chk("erase pulses", 8'(n_erase - e0), 8'(exp_busy != 0));
        if (exp_busy != 0) chk("space", {6'h0, space}, {6'h0, sp});
    endtask
    task automatic t_launch();
        chk("flash_control reset", fc, fla_pkg::FLASH_CONTROL_RESET);
        chk("lock reset", {5'h0, lock_bits}, {5'h0, fla_pkg::LOCK_DELIVERED});
        chk("nv access internal", {7'h0, nv_ok}, 8'h01);
        for (int s = 0; s < 3; s++) try_launch(2'(s), 1'b0, 6);
        chk("prog pulses", n_prog[7:0], 8'h03);
        try_launch(fla_pkg::SPACE_RESERVED, 1'b0, 0);
        try_launch(fla_pkg::SPACE_USER, 1'b1, 0);
        i_cpu.wr({fla_pkg::KEY_SECOND, 4'h1});
        chk("lone second key", fc, {fla_pkg::KEY_SECOND, 4'h0});
    endtask
    task automatic t_decode();
        logic [1:0] er;
        logic [1:0] ew;
        set_lock(3'h7, 1'b0);
        chk("lock locked", {5'h0, lock_bits}, {5'h0, fla_pkg::LOCK_DELIVERED});
        set_lock(3'h7, 1'b1);
        {exec_from_boot, pc} = {1'b0, 16'h8000};
        try_launch(fla_pkg::SPACE_USER, 1'b0, 0);
        chk("nv access external", {7'h0, nv_ok}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {eee, pin} = {i[2], i[0]};
            i_cpu.wr({4'h0, i[1], 3'h0});
            repeat (3) @(negedge core_clk);
            chk("map bit", {7'h0, fc[fla_pkg::MAP_BIT]}, {7'h0, i[1]});
            chk("pin follows", {7'h0, ea_lat}, {7'h0, i[0]});
            er = (i[2] && !i[1]) ? fla_pkg::DST_EEPROM : fla_pkg::DST_XRAM;
            ew = i[1] ? (i[0] ? fla_pkg::DST_LATCH : fla_pkg::DST_XRAM)
                : (i[2] ? fla_pkg::DST_EEPROM : fla_pkg::DST_XRAM);
            i_cpu.pulse(1);
            chk("read dest", {6'h0, dest}, {6'h0, er});
            i_cpu.pulse(2);
            chk("write dest", {6'h0, dest}, {6'h0, ew});
        end
    endtask
    task automatic t_levels();
        logic [2:0] code [4] = '{3'h7, 3'h6, 3'h5, 3'h3};
        logic [3:0] exp [4] = '{4'h6, 4'ha, 4'h8, 4'h9};
        // levels one to four set in turn, each checked on table read block, program and verify grants and roll-over block
        for (int l = 0; l < 4; l++) begin
            set_lock(code[l], 1'b1);
            {par_prog, par_ver} = 2'h3;
            i_cpu.pulse(3);
            chk("level outputs", {4'h0, tblk, pgr, vgr, xblk}, {4'h0, exp[l]});
            {par_prog, par_ver} = 2'h0;
        end
        {pc, pin} = {fla_pkg::ROLL_LIMIT, 1'b0};
        repeat (3) @(negedge core_clk);
        chk("no roll-over", {7'h0, xblk}, 8'h00);
        chk("pin held when locked", {7'h0, ea_lat}, 8'h01);
        // second reset: pin now low must be caught once released
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("pin latched at reset", {7'h0, ea_lat}, 8'h00);
        chk("lock after reset", {5'h0, lock_bits}, {5'h0, fla_pkg::LOCK_DELIVERED});
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        t_launch();
        t_decode();
        t_levels();
        close_out();
    end
endmodule
